// ==== rtl/srb_defs.svh ====
`ifndef SRB_DEFS_SVH
`define SRB_DEFS_SVH
`define SRB_REG_CTRL      3'h0
`define SRB_REG_CMD       3'h1
`define SRB_REG_STATUS    3'h2
`define SRB_REG_PEER_LO   3'h3
`define SRB_REG_PEER_HI   3'h4
`define SRB_CTRL_MODE     1:0
`define SRB_CTRL_BAUD     5:2
`define SRB_CTRL_PAR      7:6
`define SRB_CTRL_STOP2    8
`define SRB_CMD_IDLE      0
`define SRB_CMD_SRST      1
`define SRB_CMD_ERRCLR    2
`define SRB_BAUD_RST      4'h3
`define SRB_PAR_RST       2'h0
`define SRB_SW_CFG        3'h7
`define SRB_CLK_HZ        200000000
`define SRB_CYC_PER_MS    (`SRB_CLK_HZ / 1000)
`define SRB_FAST_BLINK_MS 1000
`define SRB_SLOW_BLINK_MS 3000
`define SRB_BLINK_ON_MS   100
`define SRB_ACT_LAMP_MS   50
`endif

// ==== rtl/srb_pkg.sv ====
package srb_pkg;
  typedef enum logic [1:0] {
    idle_command_mode,
    auto_connect_master_mode,
    last_peer_slave_mode,
    open_discoverable_mode
  } srb_mode_t;
  typedef enum logic [2:0] {ser_idle, ser_start, ser_data, ser_par, ser_stop} srb_ser_t;
endpackage

// ==== rtl/srb_bridge.sv ====
`timescale 1ns/100ps
`include "srb_defs.svh"
module srb_bridge #(
  parameter int DEPTH    = 64,
  parameter int RTS_FREE = 16,
  parameter int FAST_CYC = `SRB_FAST_BLINK_MS * `SRB_CYC_PER_MS,
  parameter int SLOW_CYC = `SRB_SLOW_BLINK_MS * `SRB_CYC_PER_MS,
  parameter int ON_CYC   = `SRB_BLINK_ON_MS * `SRB_CYC_PER_MS,
  parameter int ACT_CYC  = `SRB_ACT_LAMP_MS * `SRB_CYC_PER_MS
) (
  input  wire logic        clk,             // 200 MHz clock
  input  wire logic        rst_n,           // Sync reset, hardware reset
  input  wire logic [4:0]  avs_address,     // Byte address
  input  wire logic        avs_read,        // Read request
  input  wire logic        avs_write,       // Write request
  input  wire logic [31:0] avs_writedata,   // Write data
  output logic [31:0]      avs_readdata,    // Read data
  output logic             avs_waitrequest, // Stall
  input  wire logic        ser_rxd,         // Serial data from host
  output logic             ser_txd,         // Serial data to host
  output logic             ser_rts_n,       // Low: host may send
  input  wire logic [2:0]  sw_baud,         // Rate switch, 7 = software
  input  wire logic        sw_flow,         // Flow control switch
  output logic [7:0]       radio_tx_data,   // Byte to radio
  output logic             radio_tx_valid,  // Byte offered
  input  wire logic        radio_tx_take,   // Radio takes byte
  input  wire logic        radio_pkt_done,  // Packet delivered
  input  wire logic        radio_pkt_retry, // Packet must be resent
  input  wire logic [7:0]  radio_rx_data,   // Byte from radio
  input  wire logic        radio_rx_valid,  // Byte offered
  output logic             radio_rx_ready,  // Byte accepted
  input  wire logic        link_up,         // Peer connected pulse
  input  wire logic [47:0] link_peer,       // Address of that peer
  input  wire logic        link_down,       // Link lost pulse
  output logic             role_master,     // Act as master
  output logic             role_slave,      // Act as slave
  output logic             discoverable,    // Answer inquiries
  output logic             connectable,     // Answer pages
  output logic             peer_only,       // Only stored peer
  output logic             connect_try,     // Keep paging stored peer
  output logic             link_refuse,     // Refused link pulse
  output logic [47:0]      peer_addr,       // Stored peer
  output logic             power_lamp,      // Power lamp
  output logic             standby_lamp,    // Standby lamp
  output logic             link_lamp,       // Link lamp
  output logic             tx_lamp,         // To-host activity
  output logic             rx_lamp          // From-host activity
);
  import srb_pkg::*;
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    srb_mode_t          mode;
    logic [3:0]         baud_sel;
    logic [1:0]         parity;
    logic               stop2;
    logic               connected;
    logic               peer_valid;
    logic [47:0]        peer;
    logic               refuse;
    logic               sw_cfg_q;
    logic [AW:0]        wr_ptr;
    logic [AW:0]        rd_ptr;
    logic [AW:0]        snd_ptr;
    logic               rts_n;
    logic               err;
    srb_ser_t           rx_st;
    logic [17:0]        rx_cnt;
    logic [2:0]         rx_bit;
    logic [7:0]         rx_sh;
    logic               rx_par;
    logic               rx_perr;
    srb_ser_t           tx_st;
    logic [17:0]        tx_cnt;
    logic [2:0]         tx_bit;
    logic [7:0]         tx_sh;
    logic               tx_par;
    logic               txd;
    logic [29:0]        blink;
    logic [23:0]        rx_act;
    logic [23:0]        tx_act;
    logic               ack;
    logic [31:0]        rdata;
    logic               power;
  } srb_state_t;

  srb_state_t s;
  srb_state_t n;
  logic [7:0] mem [DEPTH];
  logic       push;
  logic [7:0] push_byte;

  // Clock cycles per bit for each rate index
  function automatic logic [17:0] srb_div(input logic [3:0] sel);
    case (sel)
      4'h0:    srb_div = 18'(`SRB_CLK_HZ / 1200);
      4'h1:    srb_div = 18'(`SRB_CLK_HZ / 2400);
      4'h2:    srb_div = 18'(`SRB_CLK_HZ / 4800);
      4'h3:    srb_div = 18'(`SRB_CLK_HZ / 9600);
      4'h4:    srb_div = 18'(`SRB_CLK_HZ / 19200);
      4'h5:    srb_div = 18'(`SRB_CLK_HZ / 38400);
      4'h6:    srb_div = 18'(`SRB_CLK_HZ / 57600);
      4'h7:    srb_div = 18'(`SRB_CLK_HZ / 115200);
      4'h8:    srb_div = 18'(`SRB_CLK_HZ / 230400);
      default: srb_div = 18'(`SRB_CLK_HZ / 9600);
    endcase
  endfunction

  logic        sw_cfg;
  logic [17:0] div;
  logic [AW:0] level;
  logic        full;
  logic        wr_hit;
  logic        rd_hit;
  logic        tx_go;
  logic [1:0]  wmode;

  assign sw_cfg = (sw_baud == `SRB_SW_CFG);
  assign div    = srb_div(sw_cfg ? s.baud_sel : {1'b0, sw_baud} + 4'h1);
  assign level  = s.wr_ptr - s.rd_ptr;
  assign full   = (level == (AW+1)'(DEPTH));
  assign wr_hit = avs_write & s.ack;
  assign rd_hit = avs_read & ~s.ack;
  assign tx_go  = radio_rx_valid & radio_rx_ready;
  assign wmode  = avs_writedata[`SRB_CTRL_MODE];

  always_comb begin
    n = s;
    n.refuse = 1'b0;
    n.power = 1'b1;
    push = 1'b0;
    push_byte = s.rx_sh;
    // Register bus: one wait state on every access
    n.ack = (avs_read | avs_write) & ~s.ack;
    if (rd_hit) begin
      case (avs_address[4:2])
        `SRB_REG_CTRL:    n.rdata = {23'h00_0000, s.stop2, s.parity, s.baud_sel, s.mode};
        `SRB_REG_STATUS:  n.rdata = {16'h0000, 7'(level), s.err, s.rts_n, sw_flow, sw_cfg,
                                     s.peer_valid, s.connected, 1'b0, s.mode};
        `SRB_REG_PEER_LO: n.rdata = s.peer[31:0];
        `SRB_REG_PEER_HI: n.rdata = {16'h0000, s.peer[47:32]};
        default:          n.rdata = 32'h0000_0000;
      endcase
    end
    n.sw_cfg_q = sw_cfg;
    if (sw_cfg & ~s.sw_cfg_q) begin
      n.baud_sel = `SRB_BAUD_RST;
    end
    if (wr_hit && avs_address[4:2] == `SRB_REG_CTRL && s.mode == idle_command_mode) begin
      n.baud_sel = avs_writedata[`SRB_CTRL_BAUD];
      n.parity = avs_writedata[`SRB_CTRL_PAR];
      n.stop2 = avs_writedata[`SRB_CTRL_STOP2];
      if (s.peer_valid || wmode == 2'(open_discoverable_mode)) begin
        n.mode = srb_mode_t'(wmode);
      end
    end
    if (wr_hit && avs_address[4:2] == `SRB_REG_CMD) begin
      if (avs_writedata[`SRB_CMD_IDLE]) begin
        n.mode = idle_command_mode;
        n.connected = 1'b0;
      end
      if (avs_writedata[`SRB_CMD_ERRCLR]) begin
        n.err = 1'b0;
      end
      if (avs_writedata[`SRB_CMD_SRST]) begin
        n.connected = 1'b0;
        n.rd_ptr = s.wr_ptr;
        n.snd_ptr = s.wr_ptr;
        n.tx_st = ser_idle;
        n.txd = 1'b1;
      end
    end
    // Link events
    if (link_down) begin
      n.connected = 1'b0;
      n.snd_ptr = n.rd_ptr;
    end else if (link_up && !s.connected) begin
      case (s.mode)
        auto_connect_master_mode, last_peer_slave_mode: begin
          if (link_peer == s.peer) begin
            n.connected = 1'b1;
          end else begin
            n.refuse = 1'b1;
          end
        end
        open_discoverable_mode: begin
          n.connected = 1'b1;
          n.peer = link_peer;
          n.peer_valid = 1'b1;
        end
        default: n.refuse = 1'b1;
      endcase
    end
    // Radio drain, packet retry
    if (radio_tx_valid && radio_tx_take) begin
      n.snd_ptr = s.snd_ptr + (AW+1)'(1);
    end
    if (radio_pkt_retry) begin
      n.snd_ptr = s.rd_ptr;
    end else if (radio_pkt_done) begin
      n.rd_ptr = s.snd_ptr;
    end
    // Host receiver
    case (s.rx_st)
      ser_idle: begin
        if (!ser_rxd) begin
          n.rx_st = ser_start;
          n.rx_cnt = {1'b0, div[17:1]};
        end
      end
      ser_start: begin
        if (s.rx_cnt != 18'h0_0000) begin
          n.rx_cnt = s.rx_cnt - 18'h0_0001;
        end else begin
          n.rx_st = ser_rxd ? ser_idle : ser_data;
          n.rx_cnt = div - 18'h0_0001;
          n.rx_bit = 3'h0;
          n.rx_par = s.parity[1];
          n.rx_perr = 1'b0;
        end
      end
      ser_data: begin
        if (s.rx_cnt != 18'h0_0000) begin
          n.rx_cnt = s.rx_cnt - 18'h0_0001;
        end else begin
          n.rx_cnt = div - 18'h0_0001;
          n.rx_sh = {ser_rxd, s.rx_sh[7:1]};
          n.rx_par = s.rx_par ^ ser_rxd;
          n.rx_bit = s.rx_bit + 3'h1;
          if (s.rx_bit == 3'h7) begin
            n.rx_st = (s.parity == 2'h1 || s.parity == 2'h2) ? ser_par : ser_stop;
          end
        end
      end
      ser_par: begin
        if (s.rx_cnt != 18'h0_0000) begin
          n.rx_cnt = s.rx_cnt - 18'h0_0001;
        end else begin
          n.rx_cnt = div - 18'h0_0001;
          n.rx_perr = s.rx_par ^ ser_rxd;
          n.rx_st = ser_stop;
        end
      end
      ser_stop: begin
        if (s.rx_cnt != 18'h0_0000) begin
          n.rx_cnt = s.rx_cnt - 18'h0_0001;
        end else begin
          n.rx_st = ser_idle;
          if (ser_rxd && !s.rx_perr) begin
            push = 1'b1;
            n.rx_act = 24'(ACT_CYC);
          end else begin
            n.err = 1'b1;
          end
        end
      end
      default: n.rx_st = ser_idle;
    endcase
    if (push) begin
      if (full && !sw_flow) begin
        n.rd_ptr = s.wr_ptr;
        n.snd_ptr = s.wr_ptr;
      end else if (full) begin
        push = 1'b0;
        n.err = 1'b1;
      end
      if (push) begin
        n.wr_ptr = s.wr_ptr + (AW+1)'(1);
      end
    end
    // RTS with hysteresis
    if (!sw_flow) begin
      n.rts_n = 1'b0;
    end else if (n.wr_ptr - n.rd_ptr == (AW+1)'(DEPTH)) begin
      n.rts_n = 1'b1;
    end else if ((AW+1)'(DEPTH) - (n.wr_ptr - n.rd_ptr) >= (AW+1)'(RTS_FREE)) begin
      n.rts_n = 1'b0;
    end
    // Host transmitter
    case (s.tx_st)
      ser_idle: begin
        n.txd = 1'b1;
        if (tx_go) begin
          n.tx_st = ser_start;
          n.tx_sh = radio_rx_data;
          n.txd = 1'b0;
          n.tx_cnt = div - 18'h0_0001;
          n.tx_par = s.parity[1];
          n.tx_act = 24'(ACT_CYC);
        end
      end
      ser_start, ser_data: begin
        if (s.tx_cnt != 18'h0_0000) begin
          n.tx_cnt = s.tx_cnt - 18'h0_0001;
        end else begin
          n.tx_cnt = div - 18'h0_0001;
          if (s.tx_st == ser_start) begin
            n.tx_st = ser_data;
            n.tx_bit = 3'h0;
            n.txd = s.tx_sh[0];
            n.tx_par = s.tx_par ^ s.tx_sh[0];
          end else if (s.tx_bit == 3'h7) begin
            if (s.parity == 2'h1 || s.parity == 2'h2) begin
              n.tx_st = ser_par;
              n.txd = s.tx_par;
            end else begin
              n.tx_st = ser_stop;
              n.txd = 1'b1;
            end
            n.tx_bit = 3'h0;
          end else begin
            n.tx_bit = s.tx_bit + 3'h1;
            n.txd = s.tx_sh[s.tx_bit + 3'h1];
            n.tx_par = s.tx_par ^ s.tx_sh[s.tx_bit + 3'h1];
          end
        end
      end
      ser_par: begin
        if (s.tx_cnt != 18'h0_0000) begin
          n.tx_cnt = s.tx_cnt - 18'h0_0001;
        end else begin
          n.tx_cnt = div - 18'h0_0001;
          n.tx_st = ser_stop;
          n.txd = 1'b1;
        end
      end
      ser_stop: begin
        if (s.tx_cnt != 18'h0_0000) begin
          n.tx_cnt = s.tx_cnt - 18'h0_0001;
        end else if (s.stop2 && s.tx_bit == 3'h0) begin
          n.tx_cnt = div - 18'h0_0001;
          n.tx_bit = 3'h1;
        end else begin
          n.tx_st = ser_idle;
        end
      end
      default: n.tx_st = ser_idle;
    endcase
    // Lamp timers
    if (s.rx_act != 24'h00_0000 && !push) begin
      n.rx_act = s.rx_act - 24'h00_0001;
    end
    if (s.tx_act != 24'h00_0000 && !tx_go) begin
      n.tx_act = s.tx_act - 24'h00_0001;
    end
    if (s.mode == idle_command_mode || s.connected ||
        s.blink >= 30'((s.mode == auto_connect_master_mode ? FAST_CYC : SLOW_CYC) - 1)) begin
      n.blink = 30'h0000_0000;
    end else begin
      n.blink = s.blink + 30'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.mode <= idle_command_mode;
      s.baud_sel <= `SRB_BAUD_RST;
      s.parity <= `SRB_PAR_RST;
      s.peer_valid <= 1'b0;
      s.peer <= 48'h0000_0000_0000;
      s.rx_st <= ser_idle;
      s.tx_st <= ser_idle;
      s.txd <= 1'b1;
    end else begin
      s <= n;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[s.wr_ptr[AW-1:0]] <= push_byte;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~s.ack;
  assign avs_readdata    = s.rdata;
  assign ser_txd         = s.txd;
  assign ser_rts_n       = s.rts_n;
  assign radio_tx_data   = mem[s.snd_ptr[AW-1:0]];
  assign radio_tx_valid  = s.connected & (s.snd_ptr != s.wr_ptr);
  assign radio_rx_ready  = s.connected & (s.tx_st == ser_idle) & ~s.ack;
  assign role_master     = (s.mode == auto_connect_master_mode);
  assign role_slave      = (s.mode == last_peer_slave_mode) | (s.mode == open_discoverable_mode);
  assign discoverable    = (s.mode == open_discoverable_mode) & ~s.connected;
  assign connectable     = role_slave & ~s.connected;
  assign peer_only       = (s.mode == last_peer_slave_mode);
  assign connect_try     = role_master & s.peer_valid & ~s.connected;
  assign link_refuse     = s.refuse;
  assign peer_addr       = s.peer;
  assign power_lamp      = s.power;
  assign standby_lamp    = (s.mode == idle_command_mode);
  assign link_lamp       = s.connected | ((s.mode != idle_command_mode) &
                           (s.blink < 30'(ON_CYC)));
  assign tx_lamp         = (s.tx_act != 24'h00_0000);
  assign rx_lamp         = (s.rx_act != 24'h00_0000);
endmodule // srb_bridge

// ==== testbench/srb_bridge_asserts.sv ====
`timescale 1ns/100ps
module srb_bridge_asserts #(
  parameter int ACT_CYC = 10
) (
  input wire logic clk,          // Clock
  input wire logic rst_n,        // Sync reset
  input wire logic sw_flow,      // Flow switch
  input wire logic ser_rts_n,    // RTS to host
  input wire logic link_up,      // Peer connect pulse
  input wire logic link_refuse,  // Refused link
  input wire logic role_master,  // Master role
  input wire logic role_slave,   // Slave role
  input wire logic discoverable, // Inquiry answer
  input wire logic connectable,  // Page answer
  input wire logic peer_only,    // Stored peer only
  input wire logic connect_try,  // Paging peer
  input wire logic power_lamp,   // Power lamp
  input wire logic standby_lamp, // Standby lamp
  input wire logic link_lamp,    // Link lamp
  input wire logic tx_lamp,      // To-host lamp
  input wire logic rx_lamp       // From-host lamp
);
  int tx_run;
  int rx_run;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Length of the current high run of each activity lamp
  always_ff @(posedge clk) begin
    tx_run <= (tx_lamp && rst_n) ? tx_run + 1 : 0;
    rx_run <= (rx_lamp && rst_n) ? rx_run + 1 : 0;
  end
  chk_power_lamp_on: assert property ($past(rst_n) |-> power_lamp)
    else $error("power lamp dark");
  chk_idle_no_role: assert property (standby_lamp |->
    !(role_master || role_slave || discoverable || connectable || connect_try))
    else $error("radio role active in idle");
  chk_idle_no_link: assert property (standby_lamp |-> !link_lamp)
    else $error("link lamp lit in idle");
  chk_master_hidden: assert property (role_master |-> !discoverable && !connectable)
    else $error("master visible");
  chk_try_master: assert property (connect_try |-> role_master)
    else $error("paging without master role");
  chk_peer_only_slave: assert property (peer_only |-> role_slave && !discoverable)
    else $error("peer-only mode wrong");
  chk_open_any_peer: assert property (discoverable |-> role_slave && !peer_only)
    else $error("open mode wrong");
  chk_refuse_cause: assert property (link_refuse |-> $past(link_up))
    else $error("refuse without request");
  chk_rts_flow_only: assert property (!sw_flow && !$past(sw_flow) |-> !ser_rts_n)
    else $error("rts raised without flow control");
  chk_tx_lamp_len: assert property ($fell(tx_lamp) |-> tx_run == ACT_CYC)
    else $error("tx lamp pulse length");
  chk_rx_lamp_len: assert property ($fell(rx_lamp) |-> rx_run == ACT_CYC)
    else $error("rx lamp pulse length");
  cover property (link_refuse);
  cover property ($rose(ser_rts_n));
  cover property ($fell(tx_lamp));
endmodule // srb_bridge_asserts
bind srb_bridge srb_bridge_asserts #(.ACT_CYC(ACT_CYC)) u_chk (.clk, .rst_n, .sw_flow,
  .ser_rts_n, .link_up, .link_refuse, .role_master, .role_slave, .discoverable,
  .connectable, .peer_only, .connect_try, .power_lamp, .standby_lamp, .link_lamp,
  .tx_lamp, .rx_lamp);

// ==== testbench/srb_host_model.sv ====
`timescale 1ns/100ps
module srb_host_model #(
  parameter int BIT = 868
) (
  input  wire logic clk,  // Clock
  input  wire logic rts_n, // Low: may send
  input  wire logic txd,   // From device
  output logic      rxd,   // To device
  output logic [7:0] got   // Last byte heard
);
  int i;
  initial rxd = 1'b1;
  // Even parity, one stop bit, LSB first
  task automatic send(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    @(posedge clk);
    while (rts_n) @(posedge clk);
    for (int k = 0; k < 11; k++) begin
      rxd <= f[k];
      repeat (BIT) @(posedge clk);
    end
  endtask
  always begin
    @(negedge txd);
    repeat (BIT + BIT / 2) @(posedge clk);
    for (i = 0; i < 8; i++) begin
      got[i] <= txd;
      repeat (BIT) @(posedge clk);
    end
  end
endmodule // srb_host_model

// ==== testbench/srb_bridge_test.sv ====
`timescale 1ns/100ps
module srb_bridge_test;
  import srb_pkg::*;
  localparam int CH = 11 * 868 + 200;
  typedef struct packed {logic [1:0] m; logic [1:0] em; logic [5:0] o; logic lk; int per;}
    srb_row_t;
  logic        clk, rst_n, avs_read, avs_write, ser_rxd, sw_flow, link_up, link_down;
  logic        radio_tx_take, radio_pkt_done, radio_pkt_retry, radio_rx_valid;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [2:0]  sw_baud;
  logic [7:0]  radio_rx_data, radio_tx_data, got;
  logic [47:0] link_peer, peer_addr;
  logic        avs_waitrequest, ser_txd, ser_rts_n, radio_tx_valid, radio_rx_ready;
  logic        role_master, role_slave, discoverable, connectable, peer_only, connect_try;
  logic        link_refuse, power_lamp, standby_lamp, link_lamp, tx_lamp, rx_lamp;
  int          errors, comparisons, cycles, n, nref;
  srb_row_t    rows [6] = '{'{2'h1, 2'h0, 6'h00, 1'b0, 200}, '{2'h2, 2'h0, 6'h00, 1'b0, 200},
    '{2'h3, 2'h3, 6'h1c, 1'b1, 600}, '{2'h1, 2'h1, 6'h21, 1'b0, 200},
    '{2'h2, 2'h2, 6'h16, 1'b0, 600}, '{2'h0, 2'h0, 6'h00, 1'b0, 200}};
  srb_bridge #(.DEPTH(2), .RTS_FREE(1), .FAST_CYC(200), .SLOW_CYC(600), .ON_CYC(20),
    .ACT_CYC(10)) uut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .ser_rxd, .ser_txd, .ser_rts_n, .sw_baud, .sw_flow,
    .radio_tx_data, .radio_tx_valid, .radio_tx_take, .radio_pkt_done, .radio_pkt_retry,
    .radio_rx_data, .radio_rx_valid, .radio_rx_ready, .link_up, .link_peer, .link_down,
    .role_master, .role_slave, .discoverable, .connectable, .peer_only, .connect_try,
    .link_refuse, .peer_addr, .power_lamp, .standby_lamp, .link_lamp, .tx_lamp, .rx_lamp);
  srb_host_model host (.clk, .rts_n(ser_rts_n), .txd(ser_txd), .rxd(ser_rxd), .got);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 96000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic cmp(input string s, input logic [47:0] e, input logic [47:0] v);
    comparisons++;
    if (v !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge clk);
  endtask
  task automatic link(input logic [47:0] p);
    nref = 0;
    @(posedge clk);
    link_up <= 1'b1;
    link_peer <= p;
    @(posedge clk);
    link_up <= 1'b0;
    repeat (3) begin
      @(negedge clk);
      nref += (link_refuse === 1'b1);
    end
  endtask
  task automatic rad(input logic [2:0] v);
    @(posedge clk);
    {radio_tx_take, radio_pkt_done, radio_pkt_retry} <= v;
    @(posedge clk);
    {radio_tx_take, radio_pkt_done, radio_pkt_retry} <= 3'h0;
    @(negedge clk);
  endtask
  // Offer one byte for the host, wait until it is taken, then wait CH cycles
  task automatic to_host(input logic [7:0] b);
    @(posedge clk);
    radio_rx_data <= b;
    radio_rx_valid <= 1'b1;
    do @(posedge clk); while (radio_rx_ready !== 1'b1);
    radio_rx_valid <= 1'b0;
    repeat (CH) @(posedge clk);
  endtask
  initial begin
    {rst_n, avs_read, avs_write, sw_flow, link_up, link_down, radio_rx_valid} = '0;
    {radio_tx_take, radio_pkt_done, radio_pkt_retry, sw_baud, avs_address} = '0;
    {avs_writedata, radio_rx_data, link_peer} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b1, 5'h00, 32'h0000_0060);
    @(posedge clk);
    sw_baud <= 3'h7;
    repeat (3) @(posedge clk);
    bus(1'b0, 5'h00, 32'h0000_0000);
    cmp("baud", 4'h3, q[5:2]);
    for (int r = 0; r < 6; r++) begin
      bus(1'b1, 5'h04, 32'h0000_0001);
      bus(1'b1, 5'h00, 32'h0000_0060 | rows[r].m);
      bus(1'b0, 5'h08, 32'h0000_0000);
      cmp("mode", rows[r].em, q[1:0]);
      cmp("roles", rows[r].o, {role_master, role_slave, discoverable, connectable,
        peer_only, connect_try});
      cmp("standby", rows[r].em == 2'h0, standby_lamp);
      n = 0;
      repeat (rows[r].per) begin
        @(negedge clk);
        n += (link_lamp === 1'b1);
      end
      cmp("blink", (rows[r].em != 2'h0) ? 20 : 0, n);
      if (rows[r].lk) begin
        link(48'h0123_4567_89ab);
        cmp("peer", 48'h0123_4567_89ab, peer_addr);
        cmp("solid", 1'b1, link_lamp);
      end
      $display("mode row %0d done", r);
    end
    bus(1'b1, 5'h00, 32'h0000_0062);
    bus(1'b1, 5'h00, 32'h0000_0063);
    bus(1'b0, 5'h08, 32'h0000_0000);
    cmp("busy mode", 2'h2, q[1:0]);
    link(48'h0000_0000_0bad);
    cmp("refuse", 1, nref);
    link(48'h0123_4567_89ab);
    bus(1'b0, 5'h08, 32'h0000_0000);
    cmp("connected", 1'b1, q[3]);
    $display("link test done");
    @(posedge clk);
    sw_flow <= 1'b1;
    host.send(8'h5a);
    host.send(8'h3c);
    bus(1'b0, 5'h08, 32'h0000_0000);
    cmp("rts full", 1'b1, ser_rts_n);
    cmp("level", 7'h02, q[15:9]);
    cmp("tx data", 8'h5a, radio_tx_data);
    cmp("tx valid", 1'b1, radio_tx_valid);
    fork
      host.send(8'hc3);
    join_none
    rad(3'h4);
    cmp("tx next", 8'h3c, radio_tx_data);
    rad(3'h1);
    cmp("tx retry", 8'h5a, radio_tx_data);
    rad(3'h4);
    rad(3'h4);
    rad(3'h2);
    cmp("rts free", 1'b0, ser_rts_n);
    repeat (CH) @(posedge clk);
    bus(1'b0, 5'h08, 32'h0000_0000);
    cmp("level", 7'h01, q[15:9]);
    $display("flow test done");
    @(posedge clk);
    sw_flow <= 1'b0;
    host.send(8'h11);
    cmp("rts open", 1'b0, ser_rts_n);
    host.send(8'h22);
    bus(1'b0, 5'h08, 32'h0000_0000);
    cmp("cleared", 7'h01, q[15:9]);
    cmp("tx kept", 8'h22, radio_tx_data);
    $display("overflow test done");
    to_host(8'ha5);
    cmp("to host", 8'ha5, got);
    bus(1'b1, 5'h04, 32'h0000_0002);
    bus(1'b0, 5'h08, 32'h0000_0000);
    cmp("soft reset", 12'h002, {q[15:9], q[3:0]});
    $display("soft reset test done");
    bus(1'b1, 5'h04, 32'h0000_0001);
    bus(1'b1, 5'h00, 32'h0000_01a3);
    host.send(8'h5a);
    bus(1'b0, 5'h08, 32'h0000_0000);
    cmp("parity error", 8'h01, q[15:8]);
    bus(1'b1, 5'h04, 32'h0000_0004);
    bus(1'b0, 5'h08, 32'h0000_0000);
    cmp("error clear", 1'b0, q[8]);
    link(48'h0000_0000_0bad);
    bus(1'b0, 5'h0c, 32'h0000_0000);
    cmp("peer low", 32'h0000_0bad, q);
    bus(1'b0, 5'h10, 32'h0000_0000);
    cmp("peer high", 32'h0000_0000, q);
    to_host(8'h3c);
    cmp("odd to host", 8'h3c, got);
    @(posedge clk);
    link_down <= 1'b1;
    @(posedge clk);
    link_down <= 1'b0;
    @(negedge clk);
    cmp("down", 2'h2, {discoverable, radio_tx_valid});
    @(posedge clk);
    sw_baud <= 3'h2;
    bus(1'b0, 5'h08, 32'h0000_0000);
    cmp("switch rate", 1'b0, q[5]);
    @(posedge clk);
    sw_baud <= 3'h7;
    bus(1'b0, 5'h00, 32'h0000_0000);
    cmp("baud again", 4'h3, q[5:2]);
    $display("open mode test done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge clk);
    cmp("hw reset", 4'hb, {standby_lamp, ser_rts_n, ser_txd, power_lamp});
    cmp("peer clear", 48'h0, peer_addr);
    bus(1'b0, 5'h08, 32'h0000_0000);
    cmp("reset mode", 2'h0, q[1:0]);
    $display("reset test done");
    print_verdict();
  end
endmodule // srb_bridge_test
